// >>> hw/adcseq_defines.vh
// Register map, field positions, reset values and counts of the converter sequencer
// Included by the sequencer; holds definitions only
`ifndef ADCSEQ_DEFINES_VH
`define ADCSEQ_DEFINES_VH

// Printed offsets are register indices; byte address is four times the index
`define ADCSEQ_IDX_RESULT       8'h19
`define ADCSEQ_IDX_CHANNEL      8'h1B
`define ADCSEQ_IDX_TRIGGER      8'h1C
`define ADCSEQ_IDX_CONTROL      8'h1D
`define ADCSEQ_ADDR_RESULT      12'h064
`define ADCSEQ_ADDR_CHANNEL     12'h06C
`define ADCSEQ_ADDR_TRIGGER     12'h070
`define ADCSEQ_ADDR_CONTROL     12'h074

// Control register fields
`define ADCSEQ_BIT_ENABLE       7
`define ADCSEQ_BIT_START        6
`define ADCSEQ_BIT_AUTO         5
`define ADCSEQ_BIT_DONE         4
`define ADCSEQ_BIT_IRQ_EN       3
`define ADCSEQ_DIV_MSB          2
`define ADCSEQ_DIV_LSB          0

`define ADCSEQ_RESET_BYTE       8'h00

// Conversion lengths in converter clock cycles
`define ADCSEQ_FIRST_CYCLES     5'd25
`define ADCSEQ_NORMAL_CYCLES    5'd13

// Sample point, converter cycles from the start of a conversion
`define ADCSEQ_HOLD_FIRST       5'd16
`define ADCSEQ_HOLD_NORMAL      5'd3

// Trigger source codes
`define ADCSEQ_TRG_FREE         3'h0
`define ADCSEQ_TRG_COMPARATOR   3'h1
`define ADCSEQ_TRG_EXT_IRQ0     3'h2
`define ADCSEQ_TRG_T0_CMP_A     3'h3
`define ADCSEQ_TRG_T0_OVF       3'h4
`define ADCSEQ_TRG_T0_CMP_B     3'h5
`define ADCSEQ_TRG_PIN_CHANGE   3'h6
`define ADCSEQ_TRG_T0_CAPTURE   3'h7

`endif

// >>> hw/adcseq_top.v
// Digital sequencer of an 8-bit successive-approximation converter, APB slave
// Assumes APB master on pclk; analog core returns a sampled 8-bit code per channel
`timescale 1ns/1ps
`include "adcseq_defines.vh"

module adcseq_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        global_irq_enable,
  input  wire        irq_vector_ack,
  input  wire        sleep_noise_or_idle,
  input  wire [6:0]  trigger_flags,
  input  wire [7:0]  analog_code_0,
  input  wire [7:0]  analog_code_1,
  input  wire [7:0]  analog_code_2,
  input  wire [7:0]  analog_code_3,
  output reg         conversion_irq,
  output reg  [1:0]  analog_channel,
  output reg         analog_powered,
  output reg         analog_sample
);

  // Maps divider code to terminal count (division factor minus one)
  function [6:0] adcseq_div_top;
    input [2:0] code;
    begin
      case (code)
        3'h0, 3'h1: adcseq_div_top = 7'h01;
        3'h2:       adcseq_div_top = 7'h03;
        3'h3:       adcseq_div_top = 7'h07;
        3'h4:       adcseq_div_top = 7'h0F;
        3'h5:       adcseq_div_top = 7'h1F;
        3'h6:       adcseq_div_top = 7'h3F;
        default:    adcseq_div_top = 7'h7F;
      endcase
    end
  endfunction

  // Selects the trigger flag; code 0 (free running) follows the done flag
  function adcseq_trig_pick;
    input [2:0] code;
    input [6:0] flags;
    input       done;
    begin
      if (code == `ADCSEQ_TRG_FREE)
        adcseq_trig_pick = done;
      else
        adcseq_trig_pick = flags[code - 3'h1];
    end
  endfunction

  // True for the four decoded register words
  function adcseq_mapped;
    input [11:0] addr;
    begin
      adcseq_mapped = (addr == `ADCSEQ_ADDR_CONTROL) || (addr == `ADCSEQ_ADDR_CHANNEL)
                      || (addr == `ADCSEQ_ADDR_TRIGGER) || (addr == `ADCSEQ_ADDR_RESULT);
    end
  endfunction

  // Conversion length; the first one after enabling is longer
  function [4:0] adcseq_conv_len;
    input first;
    begin
      if (first)
        adcseq_conv_len = `ADCSEQ_FIRST_CYCLES;
      else
        adcseq_conv_len = `ADCSEQ_NORMAL_CYCLES;
    end
  endfunction

  // Sample point of a conversion of the given length
  function [4:0] adcseq_hold_at;
    input [4:0] len;
    begin
      if (len == `ADCSEQ_FIRST_CYCLES)
        adcseq_hold_at = `ADCSEQ_HOLD_FIRST;
      else
        adcseq_hold_at = `ADCSEQ_HOLD_NORMAL;
    end
  endfunction

  reg        enable_reg;
  reg        busy_reg;
  reg        auto_reg;
  reg        done_reg;
  reg        irq_en_reg;
  reg  [2:0] div_sel_reg;
  reg  [1:0] chan_reg;
  reg  [2:0] trig_sel_reg;
  reg  [7:0] result_reg;
  reg  [6:0] presc_reg;
  reg  [4:0] cyc_reg;
  reg  [4:0] len_reg;
  reg        first_reg;
  reg        pend_reg;
  reg        running_reg;
  reg        trig_prev_reg;
  reg        sleep_prev_reg;

  wire       acc        = psel & penable;
  wire       wr         = acc & pwrite;
  wire       setup      = psel & ~penable;
  wire       setup_rd   = setup & ~pwrite;
  wire       wr_ctl     = wr && (paddr == `ADCSEQ_ADDR_CONTROL);
  wire       wr_chan    = wr && (paddr == `ADCSEQ_ADDR_CHANNEL);
  wire       wr_trig    = wr && (paddr == `ADCSEQ_ADDR_TRIGGER);
  wire       en_wr      = wr_ctl && pwdata[`ADCSEQ_BIT_ENABLE];
  wire       dis_wr     = wr_ctl && !pwdata[`ADCSEQ_BIT_ENABLE];
  wire       done_clr   = irq_vector_ack || (wr_ctl && pwdata[`ADCSEQ_BIT_DONE]);
  wire       clk_tick   = enable_reg && (presc_reg == adcseq_div_top(div_sel_reg));
  wire       trig_now   = adcseq_trig_pick(trig_sel_reg, trigger_flags, done_reg);
  // Free running selection is masked so switching to it never fakes an edge
  wire       trig_edge  = auto_reg && trig_now && !trig_prev_reg
                          && (trig_sel_reg != `ADCSEQ_TRG_FREE);
  wire       finishing  = running_reg && clk_tick && (cyc_reg == len_reg - 5'd1);
  wire       free_run   = auto_reg && (trig_sel_reg == `ADCSEQ_TRG_FREE);
  wire       sleep_edge = sleep_noise_or_idle && !sleep_prev_reg;
  // A start while disabled is dropped; the enable must come in the same write
  wire       start_wr   = en_wr && pwdata[`ADCSEQ_BIT_START];
  // Sleep start needs an idle, enabled converter in single mode
  wire       sleep_go   = sleep_edge && enable_reg && !busy_reg && !auto_reg;
  wire       trig_go    = trig_edge && enable_reg && !busy_reg;
  // Hold point sits later in the first conversion while the core settles
  wire [4:0] hold_cyc   = adcseq_hold_at(len_reg) - 5'd1;
  reg  [7:0] sample_code;

  // The core reads the locked channel, never the buffer software writes
  always @* begin
    case (analog_channel)
      2'h0:    sample_code = analog_code_0;
      2'h1:    sample_code = analog_code_1;
      2'h2:    sample_code = analog_code_2;
      default: sample_code = analog_code_3;
    endcase
  end

  // APB handshake: one access cycle, no wait states, error on unmapped words
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~adcseq_mapped(paddr);
    end
  end

  // Read data registered at setup so it stands through the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= 32'h00000000;
      if (setup_rd) begin
        if (paddr == `ADCSEQ_ADDR_CONTROL)
          prdata <= {24'h000000, enable_reg, busy_reg, auto_reg, done_reg,
                     irq_en_reg, div_sel_reg};
        else if (paddr == `ADCSEQ_ADDR_CHANNEL)
          prdata <= {30'h00000000, chan_reg};
        else if (paddr == `ADCSEQ_ADDR_TRIGGER)
          prdata <= {29'h00000000, trig_sel_reg};
        else if (paddr == `ADCSEQ_ADDR_RESULT)
          prdata <= {24'h000000, result_reg};
      end
    end
  end

  // Control fields; writes take effect at the edge ending the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg  <= 1'b0;
      auto_reg    <= 1'b0;
      irq_en_reg  <= 1'b0;
      div_sel_reg <= 3'h0;
    end else if (wr_ctl) begin
      enable_reg  <= pwdata[`ADCSEQ_BIT_ENABLE];
      auto_reg    <= pwdata[`ADCSEQ_BIT_AUTO];
      irq_en_reg  <= pwdata[`ADCSEQ_BIT_IRQ_EN];
      div_sel_reg <= pwdata[`ADCSEQ_DIV_MSB:`ADCSEQ_DIV_LSB];
    end
  end

  // Trigger source select
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      trig_sel_reg <= 3'h0;
    else if (wr_trig)
      trig_sel_reg <= pwdata[2:0];
  end

  // Channel buffer; the core copy is refreshed only outside a conversion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      chan_reg <= 2'h0;
    else if (wr_chan)
      chan_reg <= pwdata[1:0];
  end

  // Edge history of the trigger and sleep inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_reg  <= 1'b0;
      sleep_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg  <= trig_now;
      sleep_prev_reg <= sleep_noise_or_idle;
    end
  end

  // Prescaler held reset while off; a trigger restarts it for a fixed latency
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      presc_reg <= 7'h00;
    else if (!enable_reg || trig_go || clk_tick)
      presc_reg <= 7'h00;
    else
      presc_reg <= presc_reg + 7'h01;
  end

  // Done flag and request; a hardware set wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg       <= 1'b0;
      conversion_irq <= 1'b0;
    end else begin
      if (finishing)
        done_reg <= 1'b1;
      else if (done_clr)
        done_reg <= 1'b0;
      conversion_irq <= (done_reg || finishing) && irq_en_reg
                        && global_irq_enable;
    end
  end

  // Core interface; channel follows the buffer while idle or at completion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_channel <= 2'h0;
      analog_powered <= 1'b0;
    end else begin
      analog_powered <= enable_reg;
      if (!busy_reg || finishing)
        analog_channel <= chan_reg;
    end
  end

  // Conversion sequencer: request, length count, completion and abort
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg      <= 1'b0;
      pend_reg      <= 1'b0;
      running_reg   <= 1'b0;
      cyc_reg       <= 5'd0;
      len_reg       <= `ADCSEQ_NORMAL_CYCLES;
      first_reg     <= 1'b0;
      result_reg    <= `ADCSEQ_RESET_BYTE;
      analog_sample <= 1'b0;
    end else begin
      analog_sample <= 1'b0;
      if (en_wr && !enable_reg)
        first_reg <= 1'b1;
      // Clearing the enable drops the conversion without setting the done flag, unless the write lands on the finishing cycle
      if (!enable_reg && !en_wr) begin
        busy_reg    <= 1'b0;
        pend_reg    <= 1'b0;
        running_reg <= 1'b0;
      end else if (dis_wr) begin
        busy_reg    <= 1'b0;
        pend_reg    <= 1'b0;
        running_reg <= 1'b0;
      end else if ((start_wr || sleep_go) && !busy_reg) begin
        busy_reg <= 1'b1;
        pend_reg <= 1'b1;
      end else if (trig_go) begin
        busy_reg    <= 1'b1;
        pend_reg    <= 1'b0;
        running_reg <= 1'b1;
        cyc_reg     <= 5'd0;
        len_reg     <= adcseq_conv_len(first_reg);
        first_reg   <= 1'b0;
      end else if (pend_reg && clk_tick) begin
        pend_reg    <= 1'b0;
        running_reg <= 1'b1;
        cyc_reg     <= 5'd0;
        len_reg     <= adcseq_conv_len(first_reg);
        first_reg   <= 1'b0;
      end else if (finishing) begin
        result_reg <= sample_code;
        cyc_reg    <= 5'd0;
        len_reg    <= `ADCSEQ_NORMAL_CYCLES;
        // Free running keeps busy high and restarts at once
        if (free_run) begin
          running_reg <= 1'b1;
        end else begin
          running_reg <= 1'b0;
          busy_reg    <= 1'b0;
        end
      end else if (running_reg && clk_tick) begin
        cyc_reg <= cyc_reg + 5'd1;
        if (cyc_reg == hold_cyc)
          analog_sample <= 1'b1;
      end
    end
  end

endmodule // adcseq_top

// >>> verification/adcseq_cpu_model.sv
// CPU side model: vectors to the conversion interrupt after a chosen delay
// Assumes the request is a registered level that stays up until the flag clears
`timescale 1ns/1ps
module adcseq_cpu_model (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       conversion_irq,
  input  wire       ack_on,
  input  wire [3:0] ack_delay,
  output reg        irq_vector_ack
);
  reg [3:0] wait_reg;
  // Saturating wait so one request never gets two vectors for delays below 15
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg       <= 4'h0;
      irq_vector_ack <= 1'b0;
    end else begin
      irq_vector_ack <= conversion_irq && ack_on && wait_reg == ack_delay;
      wait_reg       <= conversion_irq ? wait_reg + {3'h0, wait_reg != 4'hF} : 4'h0;
    end
  end
endmodule // adcseq_cpu_model

// >>> verification/adcseq_props.sv
// Port assertions of the converter sequencer
// Bound into adcseq_top; sees its ports only
`timescale 1ns/1ps
`include "adcseq_defines.vh"
module adcseq_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        global_irq_enable,
  input logic        irq_vector_ack,
  input logic        conversion_irq,
  input logic        analog_powered,
  input logic        analog_sample
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup  = psel && !penable;
  wire mapped = paddr == `ADCSEQ_ADDR_RESULT || paddr == `ADCSEQ_ADDR_CHANNEL
             || paddr == `ADCSEQ_ADDR_TRIGGER || paddr == `ADCSEQ_ADDR_CONTROL;
  a_apb_answer: assert property (setup |=> pready) else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_unmapped_err: assert property (setup && !mapped |=> pslverr)
    else $error("no error on unmapped address");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_irq_global: assert property (conversion_irq |-> $past(global_irq_enable))
    else $error("request without global enable");
  a_ack_clears: assert property (irq_vector_ack |-> ##2 !conversion_irq)
    else $error("request kept after vector");
  a_power_follow: assert property (pready && pwrite && paddr == `ADCSEQ_ADDR_CONTROL
    |-> ##2 analog_powered == $past(pwdata[7], 2)) else $error("power not following enable");
  a_sample_pulse: assert property (analog_sample |=> !analog_sample)
    else $error("sample longer than a cycle");
  a_sample_power: assert property (analog_sample |-> analog_powered)
    else $error("sample while powered down");
  c_irq: cover property (conversion_irq);
  c_vector: cover property (irq_vector_ack);
  c_unmapped: cover property (setup && !mapped);
endmodule // adcseq_props
bind adcseq_top adcseq_props u_adcseq_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
  .irq_vector_ack(irq_vector_ack), .conversion_irq(conversion_irq),
  .analog_powered(analog_powered), .analog_sample(analog_sample));

// >>> verification/tb.sv
// Self-checking bench of the converter sequencer over APB
// Assumes the design, the CPU model and the bound checker are compiled with it
`timescale 1ns/1ps
`include "adcseq_defines.vh"
module tb;
  localparam logic [11:0] CH = `ADCSEQ_ADDR_CHANNEL;
  localparam logic [11:0] TR = `ADCSEQ_ADDR_TRIGGER;
  localparam logic [11:0] CT = `ADCSEQ_ADDR_CONTROL;
  localparam logic [11:0] RS = `ADCSEQ_ADDR_RESULT;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, glob, sleep, ack_on;
  logic        irq, ack, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0]  flags;
  int          miscompares, checks_done, t0;
  int          cyc = 0;
  adcseq_top u_adcseq_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_irq_enable(glob), .irq_vector_ack(ack),
    .sleep_noise_or_idle(sleep), .trigger_flags(flags), .analog_code_0(8'h3C),
    .analog_code_1(8'h5A), .analog_code_2(8'hA5), .analog_code_3(8'hC3),
    .conversion_irq(irq), .analog_channel(), .analog_powered(), .analog_sample());
  adcseq_cpu_model u_adcseq_cpu_model (.pclk(pclk), .presetn(presetn), .conversion_irq(irq),
    .ack_on(ack_on), .ack_delay(4'h3), .irq_vector_ack(ack));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer sampled where settled, i.e. the values the next rising edge sees
    do begin
      @(negedge pclk);
      rdy = pready;
      q = prdata;
      slv = pslverr;
      @(posedge pclk);
    end while (rdy !== 1'b1 && ++n < 50);
    if (n == 50) miscompares++;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string w);
    apb(1'b0, a, 32'h0);
    chk(w, {24'h0, e}, q);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do apb(1'b0, CT, 32'h0); while (q[6] !== 1'b0 && ++n < 1000);
  endtask
  task automatic t_regs();
    rd(CT, 8'h00, "control"); rd(TR, 8'h00, "trigger"); rd(RS, 8'h00, "result");
    rd(12'h000, 8'h00, "unmapped");
    chk("slverr", 32'h1, {31'h0, slv});
    apb(1'b1, CH, 32'hFF); rd(CH, 8'h03, "chan bits");
    apb(1'b1, TR, 32'hFF); rd(TR, 8'h07, "trig bits");
    apb(1'b1, TR, 32'h00);
  endtask
  task automatic t_first();
    apb(1'b1, CH, 32'h02);
    apb(1'b1, CT, 32'hC0);
    t0 = cyc;
    rd(CT, 8'hC0, "busy");
    while (cyc < t0 + 46) @(posedge pclk);
    rd(CT, 8'hC0, "long first");
    idle();
    rd(CT, 8'h90, "done");
    rd(RS, 8'hA5, "result");
  endtask
  task automatic t_norm();
    apb(1'b1, CT, 32'hD8);
    t0 = cyc;
    apb(1'b1, CH, 32'h03);
    idle();
    chk("short", 32'h1, {31'h0, cyc - t0 >= 26 && cyc - t0 <= 36});
    rd(RS, 8'hA5, "old chan");
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    glob <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    glob <= 1'b1;
    apb(1'b1, CT, 32'h98); rd(CT, 8'h88, "w1c");
  endtask
  task automatic t_sleep();
    ack_on <= 1'b1; sleep <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(CT, 8'hC8, "sleep start");
    sleep <= 1'b0;
    idle();
    rd(RS, 8'hC3, "new chan");
    repeat (8) @(posedge pclk);
    rd(CT, 8'h88, "vector clear");
    ack_on <= 1'b0;
  endtask
  task automatic t_div();
    int f;
    for (int d = 0; d < 8; d++) begin
      f = d < 2 ? 2 : 1 << d;
      apb(1'b1, CT, 32'hD0 | d);
      t0 = cyc;
      idle();
      chk("divider", 32'h1, {31'h0, cyc - t0 >= 13 * f && cyc - t0 <= 14 * f + 8});
    end
    apb(1'b1, CT, 32'hD0); repeat (10) @(posedge pclk);
    apb(1'b1, CT, 32'h00); rd(CT, 8'h00, "abort");
    repeat (60) @(posedge pclk);
    rd(CT, 8'h00, "no done");
  endtask
  task automatic t_auto();
    for (int s = 1; s < 8; s++) begin
      apb(1'b1, TR, s); apb(1'b1, CT, 32'hB0);
      flags <= 7'h01 << (s - 1);
      repeat (4) @(posedge pclk);
      rd(CT, 8'hE0, "trigger");
      flags <= 7'h00; repeat (2) @(posedge pclk); flags <= 7'h01 << (s - 1);
      idle();
      rd(CT, 8'hB0, "no retrigger");
      flags <= 7'h00;
    end
    apb(1'b1, CT, 32'h90); flags <= 7'h7F;
    repeat (8) @(posedge pclk);
    rd(CT, 8'h80, "auto off");
    flags <= 7'h01; apb(1'b1, TR, 32'h2); apb(1'b1, CT, 32'hA0);
    apb(1'b1, TR, 32'h1); rd(CT, 8'hE0, "switch edge");
    idle();
    apb(1'b1, TR, 32'h0); rd(CT, 8'hB0, "free select");
    apb(1'b1, CT, 32'hE0);
    repeat (100) @(posedge pclk);
    rd(CT, 8'hF0, "free run");
    apb(1'b1, CT, 32'h00);
  endtask
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_sim();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, glob, sleep, ack_on, flags} = '0;
    {miscompares, checks_done} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs(); t_first(); glob <= 1'b1; t_norm(); t_sleep(); t_div(); t_auto();
    end_sim();
  end
endmodule // tb
